// [rtl/uart_host_port_map.vh]
// constants for the host-side parallel port of a four-channel uart
// assumes the includer works at a 250 mhz system clock
`ifndef UART_HOST_PORT_MAP_VH
`define UART_HOST_PORT_MAP_VH
`define CLK_PERIOD_PS 4000
`define SETUP_TIME_NS 10
`define STROBE_TIME_NS 40
`define HOLD_TIME_NS 10
`define CYC_OF(ns) (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SETUP_CYCLES `CYC_OF(`SETUP_TIME_NS)
`define STROBE_CYCLES `CYC_OF(`STROBE_TIME_NS)
`define HOLD_CYCLES `CYC_OF(`HOLD_TIME_NS)
`define CHAN_A 2'h0
`define CHAN_B 2'h1
`define CHAN_C 2'h2
`define CHAN_D 2'h3
`endif

// [rtl/phase_timer.v]
// down counter that pulses done when a loaded count has run out
// assumes load and count come from logic on the same clock
`timescale 1ns/1ps
module phase_timer #(
	parameter WIDTH = 8
) (
	input wire clk_in,
	input wire arst_n_in,
	input wire load_in,
	input wire [WIDTH-1:0] count_in,
	output reg done_out
);
	reg [WIDTH-1:0] remaining;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			remaining <= {WIDTH{1'b0}};
			done_out <= 1'b0;
		end else if (load_in) begin
			remaining <= count_in;
			done_out <= 1'b0;
		end else if (remaining != {WIDTH{1'b0}}) begin
			remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
			done_out <= (remaining == {{(WIDTH-1){1'b0}}, 1'b1});
		end else begin
			done_out <= 1'b0;
		end
	end
endmodule

// [rtl/uart_host_port.v]
// host controller driving the parallel register port of a four-channel uart
// assumes the device pins connect directly; the bench resolves the data wire from the enable
// Overview of operation
// [R1] drive three-bit register address every access
// [R2] eight-bit data bus; host drives on writes
// [R3] mode input chooses strobe or direction style
// [R4] read strobe low, capture data at rise
// [R5] write strobe low, data held through rise
// [R6] strobe mode: one chip select per channel
// [R7] direction mode: read strobe held high
// [R8] direction mode: write pin high reads
// [R9] direction mode: channel a select qualifies
// [R10] direction mode: b, c selects carry channel
// [R11] direction mode: channel d select held high
// [R12] channel number binary, a=00 to d=11
// [R13] device floats bus outside selected reads
`timescale 1ns/1ps
`include "uart_host_port_map.vh"
module uart_host_port #(
	parameter CNT_WIDTH = 8,
	parameter SETUP_CYC = `SETUP_CYCLES,
	parameter STROBE_CYC = `STROBE_CYCLES,
	parameter HOLD_CYC = `HOLD_CYCLES
) (
	input wire CLK_SYS_IN,
	input wire ARST_N_IN,
	input wire STROBE_MODE_IN,
	input wire REQ_VALID_IN,
	input wire REQ_WRITE_IN,
	input wire [1:0] REQ_CHAN_IN,
	input wire [2:0] REQ_ADDR_IN,
	input wire [7:0] REQ_WDATA_IN,
	output reg REQ_READY_OUT,
	output reg RESP_VALID_OUT,
	output reg [7:0] RESP_RDATA_OUT,
	output reg [2:0] REG_ADDR_OUT,
	input wire [7:0] HOST_DATA_IN,
	output reg [7:0] HOST_DATA_OUT,
	output reg HOST_DATA_OE_OUT,
	output reg READ_STROBE_N_OUT,
	output reg WRITE_STROBE_N_OUT,
	output reg CHAN_A_SELECT_N_OUT,
	output reg CHAN_B_SELECT_N_OUT,
	output reg CHAN_C_SELECT_N_OUT,
	output reg CHAN_D_SELECT_N_OUT,
	output reg BUS_STYLE_OUT
);
	localparam IDLE = 2'h0;
	localparam SETUP = 2'h1;
	localparam STROBE = 2'h2;
	localparam HOLD = 2'h3;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] data_meta;
	reg [7:0] data_sync;
	reg mode_meta;
	reg mode_sync;
	reg is_write;
	reg load;
	reg [CNT_WIDTH-1:0] load_count;
	reg next_is_write;
	reg next_req_ready;
	reg next_resp_valid;
	reg [7:0] next_resp_rdata;
	reg [2:0] next_reg_addr;
	reg [7:0] next_host_data;
	reg next_host_data_oe;
	reg next_read_strobe_n;
	reg next_write_strobe_n;
	reg [3:0] next_select_n;
	reg next_bus_style;
	wire [3:0] select_n;
	wire take;
	wire timer_done;

	// chip select lines for a channel in strobe mode: one low, others high
	function [3:0] sel_onehot_n;
		input [1:0] c;
		begin
			sel_onehot_n = ~(4'h1 << c);
		end
	endfunction

	// direction mode: channel number on the b and c pins, a and d parked high
	function [3:0] dir_select_n;
		input [1:0] c;
		begin
			dir_select_n = {1'b1, c[1], c[0], 1'b1};
		end
	endfunction

	// timer load for the phase that is being entered
	function [CNT_WIDTH-1:0] phase_cycles;
		input [1:0] s;
		begin
			case (s)
				SETUP: begin
					phase_cycles = SETUP_CYC[CNT_WIDTH-1:0];
				end
				STROBE: begin
					phase_cycles = STROBE_CYC[CNT_WIDTH-1:0];
				end
				HOLD: begin
					phase_cycles = HOLD_CYC[CNT_WIDTH-1:0];
				end
				default: begin
					phase_cycles = {CNT_WIDTH{1'b0}};
				end
			endcase
		end
	endfunction

	// two flip-flops on the pin inputs
	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			data_meta <= 8'h00;
			data_sync <= 8'h00;
			mode_meta <= 1'b1;
			mode_sync <= 1'b1;
		end else begin
			data_meta <= HOST_DATA_IN;
			data_sync <= data_meta;
			mode_meta <= STROBE_MODE_IN;
			mode_sync <= mode_meta;
		end
	end

	phase_timer #(
		.WIDTH(CNT_WIDTH)
	) u_timer (
		.clk_in(CLK_SYS_IN),
		.arst_n_in(ARST_N_IN),
		.load_in(load),
		.count_in(load_count),
		.done_out(timer_done)
	);

	assign select_n = {CHAN_D_SELECT_N_OUT, CHAN_C_SELECT_N_OUT, CHAN_B_SELECT_N_OUT,
		CHAN_A_SELECT_N_OUT};
	assign take = REQ_VALID_IN && REQ_READY_OUT;

	always @* begin
		next_state = state;
		load = 1'b0;
		load_count = {CNT_WIDTH{1'b0}};
		case (state)
			IDLE: begin
				if (take) begin
					next_state = SETUP;
					load = 1'b1;
					load_count = phase_cycles(SETUP);
				end
			end
			SETUP: begin
				if (timer_done) begin
					next_state = STROBE;
					load = 1'b1;
					load_count = phase_cycles(STROBE);
				end
			end
			STROBE: begin
				if (timer_done) begin
					next_state = HOLD;
					load = 1'b1;
					load_count = phase_cycles(HOLD);
				end
			end
			HOLD: begin
				if (timer_done) begin
					next_state = IDLE;
				end
			end
			default: begin
				next_state = IDLE;
			end
		endcase
	end

	// handshake side: ready, read return and the latched direction
	always @* begin
		next_is_write = is_write;
		next_req_ready = REQ_READY_OUT;
		next_resp_valid = 1'b0;
		next_resp_rdata = RESP_RDATA_OUT;
		case (state)
			IDLE: begin
				next_req_ready = !take;
				if (take) begin
					next_is_write = REQ_WRITE_IN;
				end
			end
			SETUP: begin
				next_req_ready = 1'b0;
			end
			STROBE: begin
				// sample before the strobe rises; device drives until then
				if (timer_done && !is_write) begin
					next_resp_rdata = data_sync; // [R4]
					next_resp_valid = 1'b1;
				end
			end
			HOLD: begin
				next_req_ready = timer_done;
			end
			default: begin
				next_req_ready = 1'b0;
			end
		endcase
	end

	// pin side: every pin but the style pin holds unless the phase that is ending moves it; the style pin follows the mode input while idle
	always @* begin
		next_reg_addr = REG_ADDR_OUT;
		next_host_data = HOST_DATA_OUT;
		next_host_data_oe = HOST_DATA_OE_OUT;
		next_read_strobe_n = READ_STROBE_N_OUT;
		next_write_strobe_n = WRITE_STROBE_N_OUT;
		next_select_n = select_n;
		next_bus_style = BUS_STYLE_OUT;
		case (state)
			IDLE: begin
				if (take) begin
					next_reg_addr = REQ_ADDR_IN; // [R1]
					next_host_data = REQ_WDATA_IN;
					next_host_data_oe = REQ_WRITE_IN; // [R2]
					next_read_strobe_n = 1'b1; // [R7]
					if (BUS_STYLE_OUT) begin
						next_write_strobe_n = 1'b1;
						next_select_n = sel_onehot_n(REQ_CHAN_IN); // [R6]
					end else begin
						next_write_strobe_n = ~REQ_WRITE_IN; // [R8]
						next_select_n = dir_select_n(REQ_CHAN_IN); // [R10] [R11] [R12]
					end
				end else begin
					// the style pin moves only between accesses, never under one
					next_bus_style = mode_sync; // [R3]
				end
			end
			SETUP: begin
				if (timer_done) begin
					if (BUS_STYLE_OUT) begin
						next_read_strobe_n = is_write; // [R4]
						next_write_strobe_n = ~is_write; // [R5]
					end else begin
						next_select_n[0] = 1'b0; // [R9]
					end
				end
			end
			STROBE: begin
				if (timer_done) begin
					if (BUS_STYLE_OUT) begin
						next_read_strobe_n = 1'b1; // [R4]
						next_write_strobe_n = 1'b1; // [R5]
					end else begin
						next_select_n[0] = 1'b1; // [R9]
					end
				end
			end
			HOLD: begin
				if (timer_done) begin
					next_host_data_oe = 1'b0; // [R2]
					next_select_n = 4'hf;
					next_write_strobe_n = 1'b1;
				end
			end
			default: begin
				next_select_n = 4'hf;
			end
		endcase
	end

	always @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state <= IDLE;
			is_write <= 1'b0;
			REQ_READY_OUT <= 1'b0;
			RESP_VALID_OUT <= 1'b0;
			RESP_RDATA_OUT <= 8'h00;
			REG_ADDR_OUT <= 3'h0;
			HOST_DATA_OUT <= 8'h00;
			HOST_DATA_OE_OUT <= 1'b0;
			READ_STROBE_N_OUT <= 1'b1;
			WRITE_STROBE_N_OUT <= 1'b1;
			CHAN_A_SELECT_N_OUT <= 1'b1;
			CHAN_B_SELECT_N_OUT <= 1'b1;
			CHAN_C_SELECT_N_OUT <= 1'b1;
			CHAN_D_SELECT_N_OUT <= 1'b1;
			BUS_STYLE_OUT <= 1'b1;
		end else begin
			state <= next_state;
			is_write <= next_is_write;
			REQ_READY_OUT <= next_req_ready;
			RESP_VALID_OUT <= next_resp_valid;
			RESP_RDATA_OUT <= next_resp_rdata;
			REG_ADDR_OUT <= next_reg_addr;
			HOST_DATA_OUT <= next_host_data;
			HOST_DATA_OE_OUT <= next_host_data_oe;
			READ_STROBE_N_OUT <= next_read_strobe_n;
			WRITE_STROBE_N_OUT <= next_write_strobe_n;
			CHAN_A_SELECT_N_OUT <= next_select_n[0];
			CHAN_B_SELECT_N_OUT <= next_select_n[1];
			CHAN_C_SELECT_N_OUT <= next_select_n[2];
			CHAN_D_SELECT_N_OUT <= next_select_n[3];
			BUS_STYLE_OUT <= next_bus_style;
		end
	end
endmodule

// [testbench/uart_dev_model.sv]
// four-channel register device on the parallel pins
// assumes the bench resolves the shared data wire
`timescale 1ns/1ps
module uart_dev_model (
	input wire sm,
	input wire [2:0] a,
	input wire rd_n,
	input wire wr_n,
	input wire [3:0] cs_n,
	input wire [7:0] d_in,
	output wire [7:0] d_out,
	output wire d_oe
);
	reg [7:0] mem [0:31];
	wire [1:0] ch = sm ? (!cs_n[0] ? 2'h0 : !cs_n[1] ? 2'h1 : !cs_n[2] ? 2'h2 : 2'h3)
		: {cs_n[2], cs_n[1]};
	wire sel = sm ? !(&cs_n) : !cs_n[0];
	wire [4:0] idx = {ch, a};
	assign d_oe = sel && (sm ? !rd_n : wr_n);
	assign d_out = mem[idx];
	always @(posedge wr_n) if (sm && sel) mem[idx] <= d_in;
	always @(posedge cs_n[0]) if (!sm && !wr_n) mem[idx] <= d_in;
endmodule

// [testbench/uart_host_port_asserts.sv]
// pin timing checks on the host port
// assumes default phase lengths
`timescale 1ns/1ps
module uart_host_port_asserts (
	input wire CLK_SYS_IN,
	input wire ARST_N_IN,
	input wire REQ_READY_OUT,
	input wire RESP_VALID_OUT,
	input wire [2:0] REG_ADDR_OUT,
	input wire [7:0] HOST_DATA_OUT,
	input wire HOST_DATA_OE_OUT,
	input wire READ_STROBE_N_OUT,
	input wire WRITE_STROBE_N_OUT,
	input wire CHAN_A_SELECT_N_OUT,
	input wire CHAN_B_SELECT_N_OUT,
	input wire CHAN_C_SELECT_N_OUT,
	input wire CHAN_D_SELECT_N_OUT,
	input wire BUS_STYLE_OUT
);
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!ARST_N_IN);
	wire [3:0] cs = {CHAN_D_SELECT_N_OUT, CHAN_C_SELECT_N_OUT, CHAN_B_SELECT_N_OUT,
		CHAN_A_SELECT_N_OUT};
	wire st = BUS_STYLE_OUT;
	a_oe_no_read: assert property (HOST_DATA_OE_OUT |-> READ_STROBE_N_OUT) else $error("oe");
	a_one_select: assert property (st |-> $countones(~cs) <= 1) else $error("cs");
	a_rd_parked: assert property (!st |-> READ_STROBE_N_OUT) else $error("rd");
	a_d_parked: assert property (!st |-> cs[3]) else $error("csd");
	a_read_len: assert property ($fell(READ_STROBE_N_OUT) |->
		!READ_STROBE_N_OUT[*8] ##4 RESP_VALID_OUT) else $error("rlen");
	a_wr_hold: assert property ($rose(WRITE_STROBE_N_OUT) && st |->
		HOST_DATA_OE_OUT && $stable(HOST_DATA_OUT) && $stable(REG_ADDR_OUT)) else $error("wh");
	a_dir_hold: assert property (!st && !cs[0] |->
		$stable(cs[2:1]) && $stable(WRITE_STROBE_N_OUT) && $stable(REG_ADDR_OUT)) else $error("dh");
	a_ready_idle: assert property ($rose(REQ_READY_OUT) |-> &cs && !HOST_DATA_OE_OUT)
		else $error("ri");
	a_style_idle: assert property ($changed(BUS_STYLE_OUT) |-> REQ_READY_OUT && &cs)
		else $error("style pin moved during an access");
	cover property ($fell(READ_STROBE_N_OUT));
	cover property ($fell(WRITE_STROBE_N_OUT) && st);
	cover property ($fell(cs[0]) && !st);
endmodule
bind uart_host_port uart_host_port_asserts u_chk (.*);

// [testbench/quad_uart_dual_mode_host_bus_bench.sv]
// bench for the host port against a device model
// assumes default phase lengths
`timescale 1ns/1ps
module quad_uart_dual_mode_host_bus_bench;
	reg CLK_SYS_IN = 0, ARST_N_IN = 0, STROBE_MODE_IN = 1, REQ_VALID_IN = 0, REQ_WRITE_IN = 0;
	reg [1:0] REQ_CHAN_IN = 0;
	reg [2:0] REQ_ADDR_IN = 0;
	reg [7:0] REQ_WDATA_IN = 0, last = 0;
	wire REQ_READY_OUT, RESP_VALID_OUT, HOST_DATA_OE_OUT, READ_STROBE_N_OUT, WRITE_STROBE_N_OUT;
	wire CHAN_A_SELECT_N_OUT, CHAN_B_SELECT_N_OUT, CHAN_C_SELECT_N_OUT, CHAN_D_SELECT_N_OUT;
	wire BUS_STYLE_OUT, dev_oe;
	wire [2:0] REG_ADDR_OUT;
	wire [7:0] RESP_RDATA_OUT, HOST_DATA_OUT, dev_out, HOST_DATA_IN;
	wire [3:0] cs = {CHAN_D_SELECT_N_OUT, CHAN_C_SELECT_N_OUT, CHAN_B_SELECT_N_OUT,
		CHAN_A_SELECT_N_OUT};
	wire [7:0] pins = {HOST_DATA_OE_OUT, BUS_STYLE_OUT, READ_STROBE_N_OUT, WRITE_STROBE_N_OUT, cs};
	integer failures = 0, compares = 0, i, n;
	reg [14:0] rows [0:9];
	assign HOST_DATA_IN = HOST_DATA_OE_OUT ? HOST_DATA_OUT : dev_oe ? dev_out : ~last;
	always @(posedge CLK_SYS_IN) last <= HOST_DATA_IN;
	initial forever #2 CLK_SYS_IN = ~CLK_SYS_IN;
	uart_host_port u_dut (.*);
	uart_dev_model u_dev (.sm(BUS_STYLE_OUT), .a(REG_ADDR_OUT), .rd_n(READ_STROBE_N_OUT),
		.wr_n(WRITE_STROBE_N_OUT), .cs_n(cs), .d_in(HOST_DATA_IN), .d_out(dev_out), .d_oe(dev_oe));
	task check(input [63:0] nm, input [7:0] exp, input [7:0] got);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("unexpected %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0) $display("Simulation passed");
			else $display("Simulation failed");
			$finish;
		end
	endtask
	task tick;
		begin
			@(negedge CLK_SYS_IN);
			n = n + 1;
			if (n > 60) begin
				failures = failures + 1;
				print_verdict;
			end
		end
	endtask
	task access(input [14:0] r);
		begin
			n = 0;
			STROBE_MODE_IN = r[14];
			while (REQ_READY_OUT !== 1'b1 || BUS_STYLE_OUT !== r[14]) tick;
			{REQ_WRITE_IN, REQ_CHAN_IN, REQ_ADDR_IN, REQ_WDATA_IN} = r[13:0];
			REQ_VALID_IN = 1;
			@(negedge CLK_SYS_IN);
			REQ_VALID_IN = 0;
			n = 1;
			if (!r[13]) begin
				while (RESP_VALID_OUT !== 1'b1) tick;
				check("latency", 8'h10, n[7:0]);
				check("rdata", r[7:0], RESP_RDATA_OUT);
			end
		end
	endtask
	initial begin
		rows = '{15'h67a5, 15'h683c, 15'h7581, 15'h7a0f, 15'h1581,
			15'h1a0f, 15'h285a, 15'h07a5, 15'h485a, 15'h5a0f};
		repeat (20) @(negedge CLK_SYS_IN);
		check("idle", 8'h7f, pins);
		ARST_N_IN = 1;
		for (i = 0; i < 10; i = i + 1) access(rows[i]);
		n = 0;
		while (REQ_READY_OUT !== 1'b1) tick;
		{REQ_WRITE_IN, REQ_CHAN_IN, REQ_ADDR_IN} = 6'h07;
		REQ_VALID_IN = 1;
		@(negedge CLK_SYS_IN);
		REQ_VALID_IN = 0;
		repeat (6) @(negedge CLK_SYS_IN);
		check("rstrobe", 8'h00, {7'h0, READ_STROBE_N_OUT});
		ARST_N_IN = 0;
		@(negedge CLK_SYS_IN);
		check("abort", 8'h7f, pins);
		ARST_N_IN = 1;
		access(15'h47a5);
		print_verdict;
	end
endmodule
